// ==== gdcfg_oc_filter.sv ====
// Overcurrent persistence filter: input must hold for the selected time.
// Assumes the raw comparator input is already synchronised to ref_clk.
`timescale 1ns/1ps
module gdcfg_oc_filter import gdcfg_pkg::*; (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [1:0] filterSel,
	input  wire logic       ocRaw,
	output logic            ocValid
);
	// Least times round up to whole cycles
	function automatic logic [7:0] filtCycles(input logic [1:0] sel);
		int n;
		n = (GDCFG_FILT_NS[sel] + GDCFG_NS_PER_CYC - 1) / GDCFG_NS_PER_CYC;
		return 8'(n);
	endfunction

	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       valid_reg;
	logic       valid_next;

	always_comb begin
		count_next = 8'h00;
		valid_next = 1'b0;
		if (ocRaw) begin
			if (count_reg + 8'h01 >= filtCycles(filterSel)) begin
				valid_next = 1'b1;
				count_next = count_reg;
			end else begin
				count_next = count_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_reg <= 8'h00;
			valid_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			valid_reg <= valid_next;
		end
	end

	assign ocValid = valid_reg;
endmodule

// ==== gdcfg_pkg.sv ====
// Package for the gate-driver configuration register bank.
// Assumes a single 20 MHz clock; register offsets are word indices on Avalon-MM.
package gdcfg_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  GDCFG_IDX_ONE      = 8'hAC;
	localparam logic [7:0]  GDCFG_IDX_TWO      = 8'hAE;
	localparam logic [7:0]  GDCFG_IDX_STATUS   = 8'hB0;
	localparam logic [7:0]  GDCFG_IDX_MASK     = 8'hB2;
	localparam logic [7:0]  GDCFG_IDX_CTRL     = 8'hB4;
	localparam logic [31:0] GDCFG_RST_ONE      = 32'h10228100;
	localparam logic [31:0] GDCFG_RST_TWO      = 32'h01200000;
	localparam logic [31:0] GDCFG_RST_MASK     = 32'h00000000;
	localparam logic [31:0] GDCFG_UNMAPPED     = 32'h00000000;
	// Field positions, register one
	localparam int GDCFG_POS_FILTER    = 12;
	localparam int GDCFG_POS_RETRY     = 11;
	localparam int GDCFG_POS_THRESH    = 10;
	localparam int GDCFG_POS_RESPONSE  = 8;
	localparam int GDCFG_POS_GAIN      = 0;
	localparam int GDCFG_POS_CLEAR     = 23;
	// Field positions, register two
	localparam int GDCFG_POS_DCOMP     = 30;
	localparam int GDCFG_POS_TDELAY    = 26;
	localparam int GDCFG_POS_SEQOFF    = 24;
	localparam int GDCFG_POS_CLIMIT    = 23;
	localparam int GDCFG_POS_VSEL      = 21;
	// Control register and status bit positions
	localparam int GDCFG_POS_AUTOGAIN  = 0;
	localparam int GDCFG_ST_OC_EVENT   = 0;
	localparam int GDCFG_ST_LATCHED    = 1;
	localparam int GDCFG_ST_RETRY_DONE = 2;
	// Clock and times
	localparam int GDCFG_CLK_HZ        = 20_000_000;
	localparam int GDCFG_FILT_NS [4]   = '{200, 600, 1200, 1600};
	localparam int GDCFG_RETRY_SHORT_MS = 5;
	localparam int GDCFG_RETRY_LONG_MS  = 500;
	localparam int GDCFG_NS_PER_CYC    = 1_000_000_000 / GDCFG_CLK_HZ;
	localparam int GDCFG_CYC_PER_MS    = GDCFG_CLK_HZ / 1000;
	localparam int GDCFG_RETRY_SHORT_CYC = GDCFG_RETRY_SHORT_MS * GDCFG_CYC_PER_MS;
	localparam int GDCFG_RETRY_LONG_CYC  = GDCFG_RETRY_LONG_MS * GDCFG_CYC_PER_MS;
	typedef enum logic [1:0] {
		GDCFG_RESP_LATCH  = 2'h0,
		GDCFG_RESP_RETRY  = 2'h1,
		GDCFG_RESP_REPORT = 2'h2,
		GDCFG_RESP_IGNORE = 2'h3
	} gdcfg_resp_t;
endpackage

// ==== gdcfg_regs.sv ====
// Gate-driver configuration register bank with overcurrent fault handling.
// Assumes an Avalon-MM master on ref_clk and a synchronous active-high reset.
// Behaviour
// - The filter-time field picks 0.2/0.6/1.2/1.6 us and overcurrent must persist that long.
// - The retry bit selects a 5 ms wait when clear and 500 ms when set before retry release.
// - The threshold bit selects the 9 A trip level when clear and 13 A when set.
// - Response code 0 turns a detected overcurrent into a latched fault held until cleared.
// - Response code 1, the reset default, gives an automatically retrying fault.
// - Response code 2 only reports an overcurrent and leaves the outputs alone.
// - Response code 3 neither reports nor acts on an overcurrent.
// - The gain field sets the sense gain only while automatic gain selection is off.
// - Gain codes 0 to 3 select 0.24, 0.48, 0.96 and 1.92 V/A, code 0 after reset.
// - The second register sits at index AEh and resets to 01200000h.
// - Bit 30 of the second register enables delay compensation and resets to off.
// - Target delay 0 follows the slew rate, codes 1 to 15 give 0.4 to 3.2 us in 0.2 us steps.
// - Bit 24 turns regulator sequencing off, resets to 1 and is cleared by writing 1.
// - The current-limit bit selects 600 mA when clear and 150 mA when set.
// - The voltage field selects 3.3, 5.0, 4.0 or 5.7 V and resets to code 1.
// - Writing 1 to fault clear clears every latched fault and the bit reads back as 0.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module gdcfg_regs import gdcfg_pkg::*; #(
	parameter int RETRY_SHORT_CYC = GDCFG_RETRY_SHORT_CYC,
	parameter int RETRY_LONG_CYC  = GDCFG_RETRY_LONG_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        overcurrentPin,
	output logic             overcurrentThresholdSel,
	output logic [1:0]       senseAmpGain,
	output logic             autoSenseGainEnable,
	output logic             delayCompEnable,
	output logic [3:0]       targetDelay,
	output logic             regulatorSequencingOff,
	output logic             regulatorCurrentLimit,
	output logic [1:0]       regulatorVoltageSel,
	output logic [1:0]       slewRate,
	output logic             outputsDisabled,
	output logic             faultReport,
	output logic             irq
);
	typedef enum logic [2:0] {
		GDCFG_S_RUN   = 3'b001,
		GDCFG_S_LATCH = 3'b010,
		GDCFG_S_RETRY = 3'b100
	} gdcfg_state_t;

	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0]  one_reg;
	logic [31:0]  one_next;
	logic [31:0]  two_reg;
	logic [31:0]  two_next;
	logic [31:0]  ctrl_reg;
	logic [31:0]  ctrl_next;
	logic [2:0]   status_reg;
	logic [2:0]   status_next;
	logic [2:0]   mask_reg;
	logic [2:0]   mask_next;
	logic [31:0]  rdata_reg;
	logic [31:0]  rdata_next;
	logic         ack_reg;
	logic         ack_next;
	gdcfg_state_t state_reg;
	gdcfg_state_t state_next;
	logic [31:0]  timer_reg;
	logic [31:0]  timer_next;
	logic         ocSync1_reg;
	logic         ocSync2_reg;
	logic         ocPrev_reg;
	logic         ocPrev_next;
	logic         ocValid;
	logic         ocEvent;
	logic         clearCmd;
	logic         wrOne;
	logic         wrTwo;
	logic [31:0]  wdOne;
	logic [31:0]  wdTwo;
	gdcfg_resp_t  resp;

	// Two flops before the comparator pin reaches any logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ocSync1_reg <= 1'b0;
			ocSync2_reg <= 1'b0;
		end else begin
			ocSync1_reg <= overcurrentPin;
			ocSync2_reg <= ocSync1_reg;
		end
	end

	gdcfg_oc_filter u_filter (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.filterSel (one_reg[GDCFG_POS_FILTER +: 2]),
		.ocRaw     (ocSync2_reg),
		.ocValid   (ocValid)
	);

	assign resp     = gdcfg_resp_t'(one_reg[GDCFG_POS_RESPONSE +: 2]);
	assign ocEvent  = ocValid && !ocPrev_reg;
	// One cycle of wait state: every access answers at the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign wrOne    = avs_write && ack_reg && avs_address == GDCFG_IDX_ONE;
	assign wrTwo    = avs_write && ack_reg && avs_address == GDCFG_IDX_TWO;
	assign wdOne    = laneMerge(one_reg, avs_writedata, avs_byteenable);
	assign wdTwo    = laneMerge(two_reg, avs_writedata, avs_byteenable);
	assign clearCmd = wrOne && wdOne[GDCFG_POS_CLEAR];

	always_comb begin
		one_next    = one_reg;
		two_next    = two_reg;
		ctrl_next   = ctrl_reg;
		mask_next   = mask_reg;
		status_next = status_reg;
		rdata_next  = rdata_reg;
		ack_next    = 1'b0;
		ocPrev_next = ocValid;
		if ((avs_read || avs_write) && !ack_reg) begin
			ack_next = 1'b1;
		end
		if (wrOne) begin
			one_next = wdOne;
			one_next[GDCFG_POS_CLEAR] = 1'b0;
		end
		if (wrTwo) begin
			two_next = wdTwo;
			// Sequencing-off bit only falls by writing a one to it
			two_next[GDCFG_POS_SEQOFF] = two_reg[GDCFG_POS_SEQOFF] &&
				!(avs_byteenable[3] && avs_writedata[GDCFG_POS_SEQOFF]);
		end
		if (avs_write && ack_reg && avs_address == GDCFG_IDX_CTRL) begin
			ctrl_next = laneMerge(ctrl_reg, avs_writedata, avs_byteenable);
		end
		if (avs_write && ack_reg && avs_address == GDCFG_IDX_MASK && avs_byteenable[0]) begin
			mask_next = avs_writedata[2:0];
		end
		if (avs_write && ack_reg && avs_address == GDCFG_IDX_STATUS && avs_byteenable[0]) begin
			status_next = status_reg & ~avs_writedata[2:0];
		end
		// Events set after the clear so a same-cycle event is kept
		if (ocEvent && resp != GDCFG_RESP_IGNORE) begin
			status_next[GDCFG_ST_OC_EVENT] = 1'b1;
		end
		if (state_reg == GDCFG_S_RUN && state_next == GDCFG_S_LATCH) begin
			status_next[GDCFG_ST_LATCHED] = 1'b1;
		end
		if (state_reg == GDCFG_S_RETRY && state_next == GDCFG_S_RUN) begin
			status_next[GDCFG_ST_RETRY_DONE] = 1'b1;
		end
		if (avs_read && !ack_reg) begin
			unique case (avs_address)
				GDCFG_IDX_ONE:    rdata_next = one_reg;
				GDCFG_IDX_TWO:    rdata_next = two_reg;
				GDCFG_IDX_STATUS: rdata_next = {29'h0, status_reg};
				GDCFG_IDX_MASK:   rdata_next = {29'h0, mask_reg};
				GDCFG_IDX_CTRL:   rdata_next = ctrl_reg;
				default:          rdata_next = GDCFG_UNMAPPED;
			endcase
		end
	end

	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		unique case (state_reg)
			GDCFG_S_RUN: begin
				if (ocEvent && resp == GDCFG_RESP_LATCH) begin
					state_next = GDCFG_S_LATCH;
				end else if (ocEvent && resp == GDCFG_RESP_RETRY) begin
					state_next = GDCFG_S_RETRY;
					timer_next = one_reg[GDCFG_POS_RETRY] ? 32'(RETRY_LONG_CYC - 1)
						: 32'(RETRY_SHORT_CYC - 1);
				end
			end
			GDCFG_S_LATCH: begin
				if (clearCmd) begin
					state_next = GDCFG_S_RUN;
				end
			end
			GDCFG_S_RETRY: begin
				// Fault clear also ends a retry early
				if (clearCmd || timer_reg == 32'h0) begin
					state_next = GDCFG_S_RUN;
				end else begin
					timer_next = timer_reg - 32'h1;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			one_reg    <= GDCFG_RST_ONE;
			two_reg    <= GDCFG_RST_TWO;
			ctrl_reg   <= 32'h00000000;
			mask_reg   <= 3'h0;
			status_reg <= 3'h0;
			rdata_reg  <= 32'h00000000;
			ack_reg    <= 1'b0;
			ocPrev_reg <= 1'b0;
			state_reg  <= GDCFG_S_RUN;
			timer_reg  <= 32'h00000000;
		end else begin
			one_reg    <= one_next;
			two_reg    <= two_next;
			ctrl_reg   <= ctrl_next;
			mask_reg   <= mask_next;
			status_reg <= status_next;
			rdata_reg  <= rdata_next;
			ack_reg    <= ack_next;
			ocPrev_reg <= ocPrev_next;
			state_reg  <= state_next;
			timer_reg  <= timer_next;
		end
	end

	assign avs_readdata            = rdata_reg;
	assign overcurrentThresholdSel = one_reg[GDCFG_POS_THRESH];
	assign autoSenseGainEnable     = ctrl_reg[GDCFG_POS_AUTOGAIN];
	// Gain field frozen at code 0 output while the automatic selector owns the amplifier
	assign senseAmpGain = autoSenseGainEnable ? 2'h0 : one_reg[GDCFG_POS_GAIN +: 2];
	assign slewRate                = one_reg[27:26];
	assign delayCompEnable         = two_reg[GDCFG_POS_DCOMP];
	assign targetDelay             = two_reg[GDCFG_POS_TDELAY +: 4];
	assign regulatorSequencingOff  = two_reg[GDCFG_POS_SEQOFF];
	assign regulatorCurrentLimit   = two_reg[GDCFG_POS_CLIMIT];
	assign regulatorVoltageSel     = two_reg[GDCFG_POS_VSEL +: 2];
	assign outputsDisabled         = state_reg != GDCFG_S_RUN;
	// Report-only mode raises the report while the filtered fault persists
	assign faultReport = state_reg != GDCFG_S_RUN ||
		(resp == GDCFG_RESP_REPORT && ocValid);
	assign irq = |(status_reg & mask_reg);
endmodule

// ==== gdcfg_regs_asserts.sv ====
// Concurrent checks for the gate-driver register bank.
// Assumes it is bound to gdcfg_regs and sees only that module's ports.
`timescale 1ns/1ps
module gdcfg_regs_chk import gdcfg_pkg::*; (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        overcurrentPin,
	input wire logic        overcurrentThresholdSel,
	input wire logic [1:0]  senseAmpGain,
	input wire logic        autoSenseGainEnable,
	input wire logic        delayCompEnable,
	input wire logic [3:0]  targetDelay,
	input wire logic        regulatorSequencingOff,
	input wire logic        regulatorCurrentLimit,
	input wire logic [1:0]  regulatorVoltageSel,
	input wire logic        outputsDisabled
);
	logic [31:0] wdLast_reg;
	logic [31:0] wdLast_next;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Write data kept one cycle so a field can be compared after its write lands
	always_comb wdLast_next = avs_writedata;
	always_ff @(posedge ref_clk) wdLast_reg <= wdLast_next;
	sequence s_ack_one;
		avs_write && !avs_waitrequest && avs_address == GDCFG_IDX_ONE && avs_byteenable[1];
	endsequence
	sequence s_ack_two;
		avs_write && !avs_waitrequest && avs_address == GDCFG_IDX_TWO && avs_byteenable == 4'hF;
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_read_one_wait: assert property ($rose(avs_read) |-> s_one_wait)
		else $error("read answer not after one wait cycle");
	a_thresh_write: assert property (s_ack_one |=> overcurrentThresholdSel == wdLast_reg[10])
		else $error("threshold select does not follow write");
	a_auto_gain_zero: assert property (autoSenseGainEnable |-> senseAmpGain == 2'h0)
		else $error("gain field used while automatic gain on");
	a_gain_follow: assert property (avs_write && !avs_waitrequest &&
		avs_address == GDCFG_IDX_ONE && avs_byteenable[0] && !autoSenseGainEnable
		|=> senseAmpGain == wdLast_reg[1:0])
		else $error("gain output does not follow written field");
	a_seq_clear_one: assert property (s_ack_two |=>
		regulatorSequencingOff == ($past(regulatorSequencingOff) && !wdLast_reg[24]))
		else $error("sequencing bit not write-one-to-clear");
	a_two_fields: assert property (s_ack_two |=> {delayCompEnable, targetDelay}
		== wdLast_reg[30:26]) else $error("delay fields do not follow write");
	a_regulator_sel: assert property (s_ack_two |=>
		{regulatorCurrentLimit, regulatorVoltageSel} == wdLast_reg[23:21])
		else $error("regulator fields do not follow write");
	a_reset_values: assert property ($past(rst) |-> regulatorSequencingOff &&
		regulatorVoltageSel == 2'h1 && !delayCompEnable && senseAmpGain == 2'h0)
		else $error("outputs not at reset values");
	a_filter_min: assert property ($rose(outputsDisabled) |->
		$past(overcurrentPin, 4) && $past(overcurrentPin, 5))
		else $error("outputs disabled by a too short overcurrent");
endmodule
bind gdcfg_regs gdcfg_regs_chk i_chk (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
	.avs_byteenable, .avs_writedata, .avs_waitrequest, .overcurrentPin, .overcurrentThresholdSel,
	.senseAmpGain, .autoSenseGainEnable, .delayCompEnable, .targetDelay, .regulatorSequencingOff,
	.regulatorCurrentLimit, .regulatorVoltageSel, .outputsDisabled);

// ==== tb.sv ====
// Self-checking bench for the gate-driver register bank.
// Assumes gdcfg_regs with its checker bound; retry counts shortened to 20 and 50.
`timescale 1ns/1ps
module tb import gdcfg_pkg::*;;
	logic        ref_clk, rst, avs_read, avs_write, overcurrentPin, avs_waitrequest;
	logic        overcurrentThresholdSel, autoSenseGainEnable, delayCompEnable, irq;
	logic        regulatorSequencingOff, regulatorCurrentLimit, outputsDisabled, faultReport;
	logic [7:0]  avs_address;
	logic [3:0]  avs_byteenable, targetDelay;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [1:0]  senseAmpGain, regulatorVoltageSel, slewRate;
	int          error_cnt, cmp_count;
	// Four-state counters so an unknown report or disable output cannot read as zero
	integer      nRep, nDis;
	localparam int FCYC [4] = '{4, 12, 24, 32};
	wire [7:0] twoOut = {delayCompEnable, targetDelay, regulatorCurrentLimit, regulatorVoltageSel};
	gdcfg_regs #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(50)) i_dut (.ref_clk, .rst, .avs_address,
		.avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.overcurrentPin, .overcurrentThresholdSel, .senseAmpGain, .autoSenseGainEnable,
		.delayCompEnable, .targetDelay, .regulatorSequencingOff, .regulatorCurrentLimit,
		.regulatorVoltageSel, .slewRate, .outputsDisabled, .faultReport, .irq);
	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// Request held until waitrequest is sampled low; one idle edge before the next
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		if (n >= 20) begin
			chk("waitrequest", 0, 1);
			summarize();
		end
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(nm, e, q);
	endtask
	// Pin held high n cycles, then watched 90 more; counts report and disable cycles
	task automatic pulse(input int n);
		nRep = 0;
		nDis = 0;
		for (int i = 0; i < n + 90; i++) begin
			overcurrentPin <= (i < n);
			@(posedge ref_clk);
			nRep += faultReport;
			nDis += outputsDisabled;
		end
	endtask
	function automatic logic [31:0] one(input logic [1:0] f, input logic r, input logic [1:0] m);
		return {16'h1022, 2'h2, f, r, 1'h0, m, 8'h00};
	endfunction
	initial begin
		rst = 1'h1;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_address = 8'h00;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0;
		overcurrentPin = 1'h0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		chk("reset outs", 8'hA0, {regulatorSequencingOff, regulatorVoltageSel, delayCompEnable,
			senseAmpGain, outputsDisabled, irq});
		rc("two reset", GDCFG_IDX_TWO, 32'h01200000);
		rc("one reset", GDCFG_IDX_ONE, 32'h10228100);
		xfer(1'h1, 8'h10, 32'hFFFFFFFF);
		rc("unmapped", 8'h10, 32'h0);
		xfer(1'h1, GDCFG_IDX_ONE, 32'h1C228100);
		chk("slew rate", 2'h3, slewRate);
		for (int i = 0; i < 16; i++) begin
			xfer(1'h1, GDCFG_IDX_TWO, {1'h0, i[0], i[3:0], 2'h0, i[1], i[2:1], 21'h0});
			rc("two", GDCFG_IDX_TWO, {1'h0, i[0], i[3:0], 2'h1, i[1], i[2:1], 21'h0});
			chk("two out", {i[0], i[3:0], i[1], i[2:1]}, twoOut);
		end
		xfer(1'h1, GDCFG_IDX_TWO, 32'h01200000);
		rc("two w1c", GDCFG_IDX_TWO, 32'h00200000);
		chk("seq off", 0, regulatorSequencingOff);
		for (int g = 0; g < 4; g++) begin
			xfer(1'h1, GDCFG_IDX_ONE, {16'h1022, 2'h2, 3'h0, g[0], 2'h1, 6'h0, g[1:0]});
			chk("gain", {g[0], g[1:0]}, {overcurrentThresholdSel, senseAmpGain});
		end
		xfer(1'h1, GDCFG_IDX_CTRL, 32'h1);
		chk("auto gain", 3'h4, {autoSenseGainEnable, senseAmpGain});
		xfer(1'h1, GDCFG_IDX_CTRL, 32'h0);
		chk("fixed gain", 3'h3, {autoSenseGainEnable, senseAmpGain});
		for (int f = 0; f < 4; f++) begin
			xfer(1'h1, GDCFG_IDX_ONE, one(f[1:0], 1'h0, GDCFG_RESP_REPORT));
			pulse(FCYC[f] - 1);
			chk("short pulse", 0, nRep);
			pulse(FCYC[f]);
			chk("report only", 1, nRep > 0 && nDis == 0);
		end
		xfer(1'h1, GDCFG_IDX_STATUS, 32'h7);
		xfer(1'h1, GDCFG_IDX_ONE, one(2'h0, 1'h0, GDCFG_RESP_IGNORE));
		pulse(10);
		chk("ignored", 0, nRep + nDis);
		rc("no event", GDCFG_IDX_STATUS, 32'h0);
		for (int r = 0; r < 2; r++) begin
			xfer(1'h1, GDCFG_IDX_ONE, one(2'h0, r[0], GDCFG_RESP_RETRY));
			pulse(10);
			chk("retry time", 1, nDis >= (r ? 50 : 20) && nDis <= (r ? 52 : 22));
			chk("resumed", 0, outputsDisabled);
		end
		rc("retry status", GDCFG_IDX_STATUS, 32'h5);
		xfer(1'h1, GDCFG_IDX_MASK, 32'h1);
		chk("irq on", 1, irq);
		xfer(1'h1, GDCFG_IDX_MASK, 32'h0);
		chk("irq masked", 0, irq);
		xfer(1'h1, GDCFG_IDX_MASK, 32'h1);
		xfer(1'h1, GDCFG_IDX_STATUS, 32'h7);
		chk("irq cleared", 0, irq);
		xfer(1'h1, GDCFG_IDX_ONE, one(2'h0, 1'h0, GDCFG_RESP_LATCH));
		pulse(10);
		chk("latched", 1, outputsDisabled && nDis > 80);
		xfer(1'h1, GDCFG_IDX_ONE, one(2'h0, 1'h0, GDCFG_RESP_LATCH) | 32'h00800000);
		chk("fault cleared", 0, outputsDisabled);
		rc("clear self", GDCFG_IDX_ONE, one(2'h0, 1'h0, GDCFG_RESP_LATCH));
		summarize();
	end
endmodule
